/* File: ucrc_unit_clock_reset_control.sv */
// unit clock and reset control: register file, oscillator model and clock gating
`timescale 1ns/1ps
`default_nettype none

module ucrc_unit_clock_reset_control
	import ucrc_pkg::*;
#(
	parameter int OSC_HALF_CYCLES = UCRC_OSC_HALF_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	input  wire logic        usb_reset_pin_n,
	output var  logic        external_clock_output_pin,
	output var  logic        osc_clk_out,
	output var  logic        internal_reset_out,
	output var  ucrc_periph_type periph_out
);

	localparam int CW = (OSC_HALF_CYCLES > 1) ? $clog2(OSC_HALF_CYCLES) : 1;

	// a half period of zero would leave the phase counter without an end point
	if (OSC_HALF_CYCLES < 1) begin : g_bad_half
		$error("OSC_HALF_CYCLES must be at least 1");
	end

	// byte address of a register from its printed index
	function automatic logic [31:0] reg_addr(input logic [31:0] idx);
		reg_addr = {idx[29:0], 2'h0};
	endfunction

	// masked write of a 16-bit control register
	function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
		masked = d & m;
	endfunction

	logic [15:0]       osc_reg;
	logic [15:0]       osc_next;
	logic [15:0]       par_reg;
	logic [15:0]       par_next;
	logic [15:0]       ser_reg;
	logic [15:0]       ser_next;
	logic [15:0]       usb_reg;
	logic [15:0]       usb_next;
	logic [15:0]       kb_reg;
	logic [15:0]       kb_next;
	logic              wr_pend_reg;
	logic [31:0]       wr_addr_reg;
	logic [15:0]       wr_data;
	logic              addr_phase;
	logic [31:0]       rd_value;
	logic              usb_pin_meta_reg;
	logic              usb_pin_sync_reg;
	logic [CW-1:0]     osc_cnt_reg;
	logic              osc_phase_reg;
	logic              osc_phase_next;
	ucrc_osc_ctrl_type ctrl;

	assign addr_phase = hsel & hready & (htrans == UCRC_HTRANS_NONSEQ | htrans == 2'h3);
	assign wr_data    = hwdata[15:0];

	// one driver for the whole struct
	assign ctrl = {osc_reg[UCRC_OSC_INTERNAL_RESET_BIT_BIT], osc_reg[UCRC_OSC_DIS_BIT],
		osc_reg[UCRC_OSC_CKO_BIT]};

	// address phase capture; writes land in the data phase
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_pend_reg <= 1'h0;
			wr_addr_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= addr_phase & hwrite;
			wr_addr_reg <= haddr;
		end
	end

	// next values of the registers, including the write in its data phase
	always_comb begin
		osc_next = osc_reg;
		par_next = par_reg;
		ser_next = ser_reg;
		usb_next = usb_reg;
		kb_next  = kb_reg;
		if (wr_pend_reg) begin
			if (wr_addr_reg == reg_addr(UCRC_IDX_OSC)) begin
				osc_next = masked(wr_data, UCRC_OSC_MASK);
			end else if (wr_addr_reg == reg_addr(UCRC_IDX_PAR)) begin
				par_next = masked(wr_data, UCRC_PAR_MASK);
			end else if (wr_addr_reg == reg_addr(UCRC_IDX_SER)) begin
				ser_next = masked(wr_data, UCRC_SER_MASK);
			end else if (wr_addr_reg == reg_addr(UCRC_IDX_USB)) begin
				usb_next = masked(wr_data, UCRC_USB_MASK);
			end else if (wr_addr_reg == reg_addr(UCRC_IDX_KBPWM)) begin
				kb_next = masked(wr_data, UCRC_KBPWM_MASK);
			end
		end
		// the internal reset bit holds the others, not its own register
		if (osc_reg[UCRC_OSC_INTERNAL_RESET_BIT_BIT]) begin
			par_next = UCRC_PAR_RESET;
			ser_next = UCRC_SER_RESET;
			usb_next = UCRC_USB_RESET;
			kb_next  = UCRC_KBPWM_RESET;
		end
	end

	// oscillator register: only the external reset touches it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			osc_reg <= UCRC_OSC_RESET;
		else
			osc_reg <= osc_next;
	end

	// peripheral control registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			par_reg <= UCRC_PAR_RESET;
			ser_reg <= UCRC_SER_RESET;
			usb_reg <= UCRC_USB_RESET;
			kb_reg  <= UCRC_KBPWM_RESET;
		end else begin
			par_reg <= par_next;
			ser_reg <= ser_next;
			usb_reg <= usb_next;
			kb_reg  <= kb_next;
		end
	end

	// read data from the next values so a read right after a write sees it
	always_comb begin
		rd_value = 32'h0000_0000;
		if (haddr == reg_addr(UCRC_IDX_OSC)) begin
			rd_value = {16'h0000, osc_next};
		end else if (haddr == reg_addr(UCRC_IDX_PAR)) begin
			rd_value = {16'h0000, par_next};
		end else if (haddr == reg_addr(UCRC_IDX_SER)) begin
			rd_value = {16'h0000, ser_next};
		end else if (haddr == reg_addr(UCRC_IDX_USB)) begin
			rd_value = {16'h0000, usb_next};
		end else if (haddr == reg_addr(UCRC_IDX_KBPWM)) begin
			rd_value = {16'h0000, kb_next};
		end
	end

	// zero wait state slave, always okay; unmapped reads give zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'h1;
			hresp     <= UCRC_HRESP_OKAY;
			hrdata    <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'h1;
			hresp     <= UCRC_HRESP_OKAY;
			if (addr_phase & ~hwrite)
				hrdata <= rd_value;
		end
	end

	// usb reset pin comes from outside and is synchronised first
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			usb_pin_meta_reg <= 1'h0;
			usb_pin_sync_reg <= 1'h0;
		end else begin
			usb_pin_meta_reg <= usb_reset_pin_n;
			usb_pin_sync_reg <= usb_pin_meta_reg;
		end
	end

	// oscillator model; stopped it rests low so gated clocks stop low
	always_comb begin
		osc_phase_next = osc_phase_reg;
		if (ctrl.oscillator_disable_bit)
			osc_phase_next = 1'h0;
		else if (osc_cnt_reg == CW'(OSC_HALF_CYCLES - 1))
			osc_phase_next = ~osc_phase_reg;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			osc_cnt_reg   <= '0;
			osc_phase_reg <= 1'h0;
		end else begin
			osc_phase_reg <= osc_phase_next;
			if (ctrl.oscillator_disable_bit || osc_cnt_reg == CW'(OSC_HALF_CYCLES - 1))
				osc_cnt_reg <= '0;
			else
				osc_cnt_reg <= osc_cnt_reg + CW'(1);
		end
	end

	// oscillator, pin and internal reset outputs, each straight from a flop
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			osc_clk_out               <= 1'h0;
			external_clock_output_pin <= 1'h1;
			internal_reset_out        <= 1'h1;
		end else begin
			osc_clk_out <= osc_phase_next;
			external_clock_output_pin <= ctrl.clock_output_control_bit | osc_phase_next;
			internal_reset_out <= osc_next[UCRC_OSC_INTERNAL_RESET_BIT_BIT];
		end
	end

	// gated clocks and active-high resets; one process owns the packed struct
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			periph_out.parallel_clk <= 1'h0;
			periph_out.serial_clk   <= 1'h0;
			periph_out.usb_clk      <= 1'h0;
			periph_out.keyboard_clk <= 1'h0;
			periph_out.pwm_clk      <= 1'h0;
			periph_out.parallel_rst <= 1'h1;
			periph_out.parallel_use <= 1'h0;
			periph_out.serial_rst   <= 1'h1;
			periph_out.usb_rst      <= 1'h1;
			periph_out.keyboard_rst <= 1'h1;
		end else begin
			periph_out.parallel_clk <= osc_phase_next & ~par_next[UCRC_PAR_CLK_BIT];
			periph_out.serial_clk <= osc_phase_next & ~ser_next[UCRC_SER_CLK_BIT];
			periph_out.usb_clk <= osc_phase_next & ~usb_next[UCRC_USB_CLK_BIT]
				& ~ctrl.oscillator_disable_bit;
			periph_out.keyboard_clk <= osc_phase_next & ~kb_next[UCRC_KB_CLK_BIT];
			periph_out.pwm_clk <= osc_phase_next & ~kb_next[UCRC_KB_PWM_CLK_BIT];
			periph_out.parallel_rst <= par_next[UCRC_PAR_RST_BIT];
			periph_out.parallel_use <= par_next[UCRC_PAR_USE_BIT];
			periph_out.serial_rst   <= ser_next[UCRC_SER_RST_BIT];
			// relies on the pin being held low across gate changes
			periph_out.usb_rst      <= ~usb_pin_sync_reg | osc_next[UCRC_OSC_INTERNAL_RESET_BIT_BIT];
			periph_out.keyboard_rst <= kb_next[UCRC_KB_RST_BIT];
		end
	end

endmodule // ucrc_unit_clock_reset_control

`default_nettype wire

/* File: ucrc_pkg.sv */
// shared constants and types of the unit clock and reset control block
package ucrc_pkg;

	// register indices as printed; the byte address is four times the index
	localparam logic [31:0] UCRC_IDX_OSC    = 32'h1500_3800;
	localparam logic [31:0] UCRC_IDX_PAR    = 32'h1500_3802;
	localparam logic [31:0] UCRC_IDX_SER    = 32'h1500_3804;
	localparam logic [31:0] UCRC_IDX_USB    = 32'h1500_380C;
	localparam logic [31:0] UCRC_IDX_KBPWM  = 32'h1500_380E;

	// field positions
	localparam int UCRC_OSC_INTERNAL_RESET_BIT_BIT   = 5;
	localparam int UCRC_OSC_DIS_BIT    = 4;
	localparam int UCRC_OSC_CKO_BIT    = 0;
	localparam int UCRC_PAR_USE_BIT    = 2;
	localparam int UCRC_PAR_RST_BIT    = 1;
	localparam int UCRC_PAR_CLK_BIT    = 0;
	localparam int UCRC_SER_RST_BIT    = 1;
	localparam int UCRC_SER_CLK_BIT    = 0;
	localparam int UCRC_USB_CLK_BIT    = 0;
	localparam int UCRC_KB_PWM_CLK_BIT = 4;
	localparam int UCRC_KB_RST_BIT     = 1;
	localparam int UCRC_KB_CLK_BIT     = 0;

	// values after reset
	localparam logic [15:0] UCRC_OSC_RESET   = 16'h0021;
	localparam logic [15:0] UCRC_PAR_RESET   = 16'h0003;
	localparam logic [15:0] UCRC_SER_RESET   = 16'h0003;
	localparam logic [15:0] UCRC_USB_RESET   = 16'h0000;
	localparam logic [15:0] UCRC_KBPWM_RESET = 16'h0013;

	// writable bits of each register; the rest read as zero
	localparam logic [15:0] UCRC_OSC_MASK   = 16'h0031;
	localparam logic [15:0] UCRC_PAR_MASK   = 16'h0007;
	localparam logic [15:0] UCRC_SER_MASK   = 16'h0003;
	localparam logic [15:0] UCRC_USB_MASK   = 16'h0001;
	localparam logic [15:0] UCRC_KBPWM_MASK = 16'h0013;

	// oscillator model: half period in core clock cycles
	localparam int UCRC_OSC_HALF_CYCLES = 1;

	localparam logic [1:0] UCRC_HTRANS_NONSEQ = 2'h2;
	localparam logic       UCRC_HRESP_OKAY    = 1'h0;

	// controls that leave the register file
	typedef struct packed {
		logic internal_reset_bit;
		logic oscillator_disable_bit;
		logic clock_output_control_bit;
	} ucrc_osc_ctrl_type;

	// gated clocks and resets handed to the peripheral controllers
	typedef struct packed {
		logic parallel_clk;
		logic parallel_rst;
		logic parallel_use;
		logic serial_clk;
		logic serial_rst;
		logic usb_clk;
		logic usb_rst;
		logic keyboard_clk;
		logic keyboard_rst;
		logic pwm_clk;
	} ucrc_periph_type;

endpackage

/* File: ucrc_properties.sv */
// port assertions of the unit clock and reset control
`timescale 1ns/1ps
`default_nettype none
module ucrc_props
	import ucrc_pkg::*;
(
	input wire logic            core_clk,
	input wire logic            rst,
	input wire logic            hsel,
	input wire logic [31:0]     haddr,
	input wire logic [1:0]      htrans,
	input wire logic            hwrite,
	input wire logic [31:0]     hwdata,
	input wire logic            hready,
	input wire logic [31:0]     hrdata,
	input wire logic            usb_reset_pin_n,
	input wire logic            external_clock_output_pin,
	input wire logic            osc_clk_out,
	input wire logic            internal_reset_out,
	input wire ucrc_periph_type periph_out
);
	logic        wph;
	logic [15:0] osc_sh;
	// bus shadow of the oscillator register; only rst reloads its reset value, UCRC_OSC_RESET
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wph <= 1'h0;
			osc_sh <= UCRC_OSC_RESET;
		end else begin
			wph <= hsel && hready && htrans[1] && hwrite && haddr == {UCRC_IDX_OSC[29:0], 2'h0};
			if (wph)
				osc_sh <= hwdata[15:0] & UCRC_OSC_MASK;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// settled for two cycles, so output register lag cannot fire these
	sequence s_dis;
		osc_sh[4] && $past(osc_sh[4]);
	endsequence
	sequence s_run;
		!osc_sh[4] && !osc_sh[0] && !$past(osc_sh[4]) && !$past(osc_sh[0]);
	endsequence
	AST_INTERNAL_RESET_BIT_HOLD: assert property (internal_reset_out [*3] |-> periph_out.parallel_rst &&
		periph_out.serial_rst && periph_out.keyboard_rst && periph_out.usb_rst &&
		!periph_out.parallel_use) else $error("resets not held");
	AST_INTERNAL_RESET_BIT_COPY: assert property ($past(osc_sh[5]) == osc_sh[5] |->
		internal_reset_out == osc_sh[5]) else $error("internal reset output wrong");
	AST_OSC_STOP: assert property (s_dis |-> !osc_clk_out) else $error("osc not low");
	AST_PIN_HIGH: assert property (osc_sh[0] && $past(osc_sh[0]) |->
		external_clock_output_pin) else $error("clock pin not high");
	AST_PIN_RUN: assert property (s_run |-> ##[0:4] $changed(external_clock_output_pin))
		else $error("clock pin stuck");
	AST_USB_STOP: assert property (s_dis |-> !periph_out.usb_clk) else $error("usb clk");
	AST_ALL_STOP: assert property (s_dis |-> !(periph_out.parallel_clk ||
		periph_out.serial_clk || periph_out.keyboard_clk || periph_out.pwm_clk))
		else $error("gated clock runs");
	AST_RSVD_ZERO: assert property (hrdata[31:16] == 16'h0000) else $error("upper read");
	AST_USB_RST: assert property ($fell(usb_reset_pin_n) |-> ##[1:4] periph_out.usb_rst)
		else $error("usb reset late");
endmodule // ucrc_props
bind ucrc_unit_clock_reset_control ucrc_props props_u (.*);
`default_nettype wire

/* File: ucrc_partner.sv */
// peripheral side: notes which gated clocks ran, drives the usb reset pin
`timescale 1ns/1ps
`default_nettype none
module ucrc_partner
	import ucrc_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            clear,
	input  wire logic            usb_release,
	input  wire ucrc_periph_type periph_out,
	output var  logic [4:0]      seen,
	output var  logic            usb_reset_pin_n
);
	always_ff @(posedge core_clk) begin
		if (clear)
			seen <= 5'h00;
		else
			seen <= seen | {periph_out.parallel_clk, periph_out.serial_clk,
				periph_out.usb_clk, periph_out.keyboard_clk, periph_out.pwm_clk};
	end
	// pin moves only on command, so it stays low across usb gate changes
	assign usb_reset_pin_n = usb_release;
endmodule // ucrc_partner
`default_nettype wire

/* File: test_unit_clock_reset_control.sv */
// self-checking bench of the unit clock and reset control
`timescale 1ns/1ps
`default_nettype none
module test_unit_clock_reset_control
	import ucrc_pkg::*;
;
	logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic clear = 1'b1, usb_release = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic hreadyout, hresp, ext_pin, osc_out, internal_reset_bit_out, usb_pin_n;
	logic [4:0] seen;
	ucrc_periph_type periph_out;
	int n_errors = 0, compares = 0, s = 94, m[6], ri;
	// last entry lies outside this block and must read zero
	logic [31:0] idx[6] = '{UCRC_IDX_OSC, UCRC_IDX_PAR, UCRC_IDX_SER, UCRC_IDX_USB,
		UCRC_IDX_KBPWM, 32'h1500_3808};
	logic [15:0] msk[5] = '{UCRC_OSC_MASK, UCRC_PAR_MASK, UCRC_SER_MASK, UCRC_USB_MASK,
		UCRC_KBPWM_MASK};
	logic [15:0] rv[5] = '{UCRC_OSC_RESET, UCRC_PAR_RESET, UCRC_SER_RESET, UCRC_USB_RESET,
		UCRC_KBPWM_RESET};
	ucrc_unit_clock_reset_control dut_u (.core_clk(core_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.usb_reset_pin_n(usb_pin_n), .external_clock_output_pin(ext_pin),
		.osc_clk_out(osc_out), .internal_reset_out(internal_reset_bit_out), .periph_out(periph_out));
	ucrc_partner part_u (.core_clk(core_clk), .clear(clear), .usb_release(usb_release),
		.periph_out(periph_out), .seen(seen), .usb_reset_pin_n(usb_pin_n));
	always #5 core_clk = ~core_clk;
	function automatic int xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdy();
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: bus wait ran out", $time);
			print_verdict();
		end
	endtask
	task automatic bus(input logic w, input int i, input int d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {idx[i][29:0], 2'h0};
		hwrite <= w;
		htrans <= UCRC_HTRANS_NONSEQ;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask
	task automatic wr(input int i, input int v);
		logic [31:0] q;
		bus(1'b1, i, v, q);
		if (i == 0 || !m[0][5])
			m[i] = v & msk[i];
		if (m[0][5])
			for (int j = 1; j < 5; j++) m[j] = rv[j];
	endtask
	task automatic rd(input int i);
		logic [31:0] q;
		bus(1'b0, i, 0, q);
		cmp(q, m[i]);
	endtask
	// each gated clock must run exactly when the oscillator runs and its gate is 0
	task automatic chk();
		logic r;
		logic [3:0] act;
		r = !m[0][4];
		act = 4'h0;
		clear <= 1'h1;
		@(posedge core_clk);
		clear <= 1'h0;
		repeat (8) begin
			@(posedge core_clk);
			act = act | {osc_out, ext_pin, !ext_pin, hresp};
		end
		cmp(32'(act), 32'({r, m[0][0] | r, !m[0][0], 1'h0}));
		cmp(32'(seen), 32'({r & !m[1][0], r & !m[2][0], r & !m[3][0], r & !m[4][0], r & !m[4][4]}));
		cmp(32'({periph_out.parallel_rst, periph_out.serial_rst, periph_out.keyboard_rst,
			periph_out.parallel_use, periph_out.usb_rst, internal_reset_bit_out}),
			32'({m[1][1], m[2][1], m[4][1], m[1][2], !usb_release | m[0][5], m[0][5]}));
	endtask
	initial begin
		for (int i = 0; i < 5; i++) m[i] = rv[i];
		m[5] = 0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 6; i++) rd(i);
		wr(1, 0);
		wr(4, 0);
		for (int i = 1; i < 5; i++) rd(i);
		chk();
		$display("reset values and internal reset done");
		wr(0, 0);
		usb_release <= 1'b1;
		chk();
		// pin held low while random writes may flip the usb gate
		usb_release <= 1'h0;
		for (int n = 0; n < 24; n++) begin
			ri = (xs() & 3) + 1;
			wr(ri, xs() & msk[ri]);
			for (int i = 1; i < 5; i++) rd(i);
			chk();
		end
		$display("random register traffic done");
		wr(1, 16'h0006);
		chk();
		repeat (100) @(posedge core_clk);
		wr(1, 16'h0004);
		chk();
		wr(2, 16'h0002);
		chk();
		wr(2, 16'h0000);
		wr(4, 16'h0012);
		chk();
		wr(4, 16'h0000);
		chk();
		$display("peripheral sequences done");
		usb_release <= 1'b0;
		wr(3, 1);
		wr(3, 0);
		chk();
		usb_release <= 1'b1;
		chk();
		wr(0, 16'h0021);
		usb_release <= 1'b0;
		wr(0, 16'h0031);
		chk();
		for (int i = 0; i < 5; i++) rd(i);
		wr(0, 16'h0021);
		wr(0, 16'h0000);
		usb_release <= 1'b1;
		chk();
		$display("oscillator stop and resume done");
		wr(0, 16'h0020);
		rd(0);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) m[i] = rv[i];
		@(posedge core_clk);
		rd(0);
		chk();
		$display("mid-run reset done");
		print_verdict();
	end
endmodule // test_unit_clock_reset_control
`default_nettype wire
